//--- rtl/spw_serial_port.sv
// serial port top: apb registers, transmitter, receiver, wake-up logic
`timescale 1ns/1ns
module spw_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line,
  output logic tx_data_o,
  output logic tx_data_oe,
  output logic sclk_o,
  output logic sclk_oe,
  output logic irq
);
  spw_pkg::spw_ctrl_one_t c1, next_c1;
  spw_pkg::spw_ctrl_two_t c2, next_c2;
  spw_pkg::spw_status_t st, next_st;
  spw_pkg::spw_baud_t bd, next_bd;
  logic [7:0] tdr, next_tdr, rdr, next_rdr, rd_q, next_rd_q, rd_mux;
  logic r8, next_r8, idle_armed, next_idle_armed;
  logic rx_meta, rx_sync, rx_rt_tick, tx_rt_tick;
  spw_pkg::spw_tx_state_t tx_state, next_tx_state;
  logic [10:0] tx_sh, next_tx_sh;
  logic [3:0] tx_bit, next_tx_bit, tx_sub, next_tx_sub, nbits;
  logic sclk_q, next_sclk, sclk_act, tx_bit_tick, tx_load, tx_done;
  spw_pkg::spw_rx_state_t rx_state, next_rx_state;
  logic [3:0] rx_rt, next_rx_rt, rx_bit, next_rx_bit;
  logic [8:0] rx_sh, next_rx_sh, rx_char;
  logic [1:0] rx_votes, next_rx_votes;
  logic rx_val, next_rx_val, rx_nz, next_rx_nz, rx_done, rx_fe;
  logic [7:0] idle_cnt, next_idle_cnt;
  logic idle_hit, addr_wake, sleep_block, wr_acc, rd_acc, hit;

  // ***************************************
  // pin synchroniser and rate generator
  // ***************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else if (ce)
    begin
      rx_meta <= rx_line;
      rx_sync <= rx_meta;
    end
  end

  spw_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .baud(bd),
    .rx_rt_tick(rx_rt_tick),
    .tx_rt_tick(tx_rt_tick)
  );

  assign nbits = c1.frame9 ? spw_pkg::BITS_FRAME9 : spw_pkg::BITS_FRAME8;

  // ***************************************
  // transmitter
  // ***************************************
  // fixed divide by sixteen after the selector
  assign tx_bit_tick = tx_rt_tick && (tx_sub == spw_pkg::RT_LAST);
  assign sclk_act = (tx_state == spw_pkg::TX_FRAME) && (tx_bit != 4'h0)
    && (tx_bit < nbits - 4'h2
      || (tx_bit == nbits - 4'h2 && c1.last_bit_clock_sel));

  always_comb
  begin
    next_tx_state = tx_state;
    next_tx_sh = tx_sh;
    next_tx_bit = tx_bit;
    next_tx_sub = tx_rt_tick ? tx_sub + 4'h1 : tx_sub;
    tx_load = 1'b0;
    tx_done = 1'b0;
    if (tx_bit_tick)
    begin
      if (tx_state != spw_pkg::TX_IDLE && tx_bit != nbits - 4'h1)
      begin
        // frame runs to its end even if disabled meanwhile
        next_tx_bit = tx_bit + 4'h1;
        next_tx_sh = {1'b1, tx_sh[10:1]};
      end
      else if (c2.tx_enable_bit && !st.tx_empty_flag)
      begin
        // stop, ninth or stop, data, start
        tx_load = 1'b1;
        next_tx_state = spw_pkg::TX_FRAME;
        next_tx_bit = 4'h0;
        next_tx_sh = {1'b1, c1.frame9 ? c1.t8 : 1'b1, tdr, 1'b0};
      end
      else if (c2.tx_enable_bit && c2.send_break_bit)
      begin
        next_tx_state = spw_pkg::TX_BREAK;
        next_tx_bit = 4'h0;
      end
      else
      begin
        tx_done = (tx_state != spw_pkg::TX_IDLE);
        next_tx_state = spw_pkg::TX_IDLE;
      end
    end
    // polarity and phase of the sync clock
    next_sclk = c1.clock_polarity_sel ^ (sclk_act
      && (c1.clock_phase_sel ? !tx_sub[3] : tx_sub[3]));
  end

  // idle and break levels come from state, not the shifter
  assign tx_data_o = (tx_state == spw_pkg::TX_FRAME) ? tx_sh[0]
    : (tx_state != spw_pkg::TX_BREAK);
  assign tx_data_oe = c2.tx_enable_bit || tx_state != spw_pkg::TX_IDLE;
  assign sclk_o = sclk_q;
  assign sclk_oe = tx_data_oe;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state <= spw_pkg::TX_IDLE;
      tx_sh <= 11'h7FF;
      tx_bit <= 4'h0;
      tx_sub <= 4'h0;
      sclk_q <= 1'b0;
    end
    else if (ce)
    begin
      tx_state <= next_tx_state;
      tx_sh <= next_tx_sh;
      tx_bit <= next_tx_bit;
      tx_sub <= next_tx_sub;
      sclk_q <= next_sclk;
    end
  end

  // ***************************************
  // receiver
  // ***************************************
  assign rx_char = c1.frame9 ? rx_sh : {1'b0, rx_sh[8:1]};

  always_comb
  begin
    next_rx_state = rx_state;
    next_rx_rt = rx_rt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_rx_votes = rx_votes;
    next_rx_val = rx_val;
    next_rx_nz = rx_nz;
    next_idle_cnt = idle_cnt;
    rx_done = 1'b0;
    rx_fe = 1'b0;
    idle_hit = 1'b0;
    if (rx_rt_tick && c2.rx_enable_bit)
    begin
      if (rx_state == spw_pkg::RX_IDLE)
      begin
        // idle line is ten or eleven bit times high
        if (!rx_sync)
          next_idle_cnt = 8'h00;
        else if (idle_cnt != {nbits, 4'h0})
          next_idle_cnt = idle_cnt + 8'h01;
        idle_hit = rx_sync && (idle_cnt == {nbits, 4'h0} - 8'h01);
        if (!rx_sync)
        begin
          next_rx_state = spw_pkg::RX_BITS;
          next_rx_rt = 4'h1;
          next_rx_bit = 4'h0;
          next_rx_nz = 1'b0;
        end
      end
      else
      begin
        next_idle_cnt = 8'h00;
        next_rx_rt = rx_rt + 4'h1;
        if (rx_rt == spw_pkg::RT_VOTE_A)
          next_rx_votes[0] = rx_sync;
        if (rx_rt == spw_pkg::RT_VOTE_B)
          next_rx_votes[1] = rx_sync;
        if (rx_rt == spw_pkg::RT_VOTE_C)
        begin
          // majority of three votes, any disagreement is noise
          next_rx_val = (rx_votes[0] & rx_votes[1])
            | (rx_sync & (rx_votes[0] | rx_votes[1]));
          next_rx_nz = rx_nz
            | !((rx_votes[0] == rx_votes[1]) && (rx_votes[1] == rx_sync));
        end
        if (rx_rt == spw_pkg::RT_LAST)
        begin
          next_rx_bit = rx_bit + 4'h1;
          if (rx_bit == 4'h0 && rx_val)
            next_rx_state = spw_pkg::RX_IDLE; // false start
          else if (rx_bit == nbits - 4'h1)
          begin
            rx_done = 1'b1;
            rx_fe = !rx_val;
            next_rx_state = spw_pkg::RX_IDLE;
          end
          else if (rx_bit != 4'h0)
            next_rx_sh = {rx_val, rx_sh[8:1]};
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= spw_pkg::RX_IDLE;
      rx_rt <= 4'h0;
      rx_bit <= 4'h0;
      rx_sh <= 9'h000;
      rx_votes <= 2'h3;
      rx_val <= 1'b1;
      rx_nz <= 1'b0;
      idle_cnt <= 8'h00;
    end
    else if (ce)
    begin
      rx_state <= next_rx_state;
      rx_rt <= next_rx_rt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      rx_votes <= next_rx_votes;
      rx_val <= next_rx_val;
      rx_nz <= next_rx_nz;
      idle_cnt <= next_idle_cnt;
    end
  end

  // ***************************************
  // apb registers and flags
  // ***************************************
  assign wr_acc = ce && psel && penable && pwrite;
  assign rd_acc = ce && psel && penable && !pwrite;
  assign hit = paddr == spw_pkg::ADDR_DATA || paddr == spw_pkg::ADDR_CTRL_ONE
    || paddr == spw_pkg::ADDR_CTRL_TWO || paddr == spw_pkg::ADDR_STATUS
    || paddr == spw_pkg::ADDR_BAUD;
  assign pready = ce;
  assign pslverr = psel && penable && !hit;
  assign prdata = {24'h000000, rd_q};
  // address character: msb of the character is set
  assign addr_wake = rx_done && c1.wake_addr && c2.rx_sleep_bit
    && (c1.frame9 ? rx_char[8] : rx_char[7]);
  assign sleep_block = c2.rx_sleep_bit && !addr_wake;

  always_comb
  begin
    case (paddr)
      spw_pkg::ADDR_DATA: rd_mux = rdr;
      spw_pkg::ADDR_CTRL_ONE: rd_mux = {r8, c1.t8, 1'b0, c1[4:0]};
      spw_pkg::ADDR_CTRL_TWO: rd_mux = c2;
      spw_pkg::ADDR_STATUS: rd_mux = st;
      spw_pkg::ADDR_BAUD: rd_mux = bd;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb
  begin
    next_c1 = c1;
    next_c2 = c2;
    next_bd = bd;
    next_st = st;
    next_tdr = tdr;
    next_rdr = rdr;
    next_r8 = r8;
    next_idle_armed = idle_armed;
    next_rd_q = (ce && psel && !penable) ? rd_mux : rd_q;
    // software writes and clears first, hardware sets below win
    if (wr_acc)
    begin
      case (paddr)
        spw_pkg::ADDR_DATA:
        begin
          next_tdr = pwdata[7:0];
          next_st.tx_empty_flag = 1'b0;
          next_st.tx_complete_flag = 1'b0;
        end
        spw_pkg::ADDR_CTRL_ONE: next_c1 = {pwdata[6], pwdata[4:0]};
        spw_pkg::ADDR_CTRL_TWO: next_c2 = pwdata[7:0];
        spw_pkg::ADDR_STATUS:
          next_st[6:1] = st[6:1] & ~{pwdata[6], 1'b0, pwdata[4:1]};
        // should be written only with both enables off
        spw_pkg::ADDR_BAUD: next_bd = pwdata[7:0];
        default: next_st = st;
      endcase
    end
    if (rd_acc && paddr == spw_pkg::ADDR_DATA)
      next_st.rx_full_flag = 1'b0;
    if (tx_load)
      next_st.tx_empty_flag = 1'b1;
    if (tx_done)
      next_st.tx_complete_flag = 1'b1;
    if (rx_done && !sleep_block)
    begin
      next_idle_armed = 1'b1;
      if (st.rx_full_flag && !(rd_acc && paddr == spw_pkg::ADDR_DATA))
        next_st.overrun_flag = 1'b1;
      else
      begin
        next_rdr = rx_char[7:0];
        next_r8 = rx_char[8];
        next_st.rx_full_flag = 1'b1;
        next_st.noise_flag = st.noise_flag | rx_nz;
        next_st.framing_error_flag = st.framing_error_flag | rx_fe;
      end
    end
    if (idle_hit && !c2.rx_sleep_bit && idle_armed)
    begin
      next_st.idle_flag = 1'b1;
      next_idle_armed = 1'b0;
    end
    if (addr_wake || (idle_hit && !c1.wake_addr))
      next_c2.rx_sleep_bit = 1'b0;
  end

  assign irq = (c2.tx_irq_en && st.tx_empty_flag)
    || (c2.tc_irq_en && st.tx_complete_flag)
    || (c2.rx_irq_en && (st.rx_full_flag || st.overrun_flag))
    || (c2.idle_irq_en && st.idle_flag);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      c1 <= spw_pkg::CTRL_ONE_RST;
      c2 <= spw_pkg::CTRL_TWO_RST;
      bd <= spw_pkg::BAUD_RST;
      st <= spw_pkg::STATUS_RST;
      tdr <= 8'h00;
      rdr <= 8'h00;
      r8 <= 1'b0;
      idle_armed <= 1'b0;
      rd_q <= 8'h00;
    end
    else if (ce)
    begin
      c1 <= next_c1;
      c2 <= next_c2;
      bd <= next_bd;
      st <= next_st;
      tdr <= next_tdr;
      rdr <= next_rdr;
      r8 <= next_r8;
      idle_armed <= next_idle_armed;
      rd_q <= next_rd_q;
    end
  end

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tx_idle_high: assert property (tx_state == spw_pkg::TX_IDLE
    |-> tx_data_o) else $error("idle line not high");
  a_tx_start_low: assert property (tx_load |=> !tx_data_o
    && tx_state == spw_pkg::TX_FRAME) else $error("no start bit");
  a_tx_break_low: assert property (tx_state == spw_pkg::TX_BREAK
    |-> !tx_data_o && !sclk_act) else $error("break not low");
  a_sclk_quiet: assert property (!sclk_act && ce
    |=> sclk_o == $past(c1.clock_polarity_sel))
    else $error("sync clock active outside data");
  a_pins_released: assert property (!c2.tx_enable_bit
    && tx_state == spw_pkg::TX_IDLE |-> !tx_data_oe && !sclk_oe)
    else $error("pins driven while disabled");
  a_tx_empty_set: assert property (tx_load |=> st.tx_empty_flag
    && tx_bit == 4'h0) else $error("tx empty not set on load");
  a_tc_after_end: assert property (tx_done |=> st.tx_complete_flag
    && tx_state == spw_pkg::TX_IDLE) else $error("tc missing");
  a_rx_full_set: assert property (rx_done && !sleep_block
    && !st.rx_full_flag |=> st.rx_full_flag && rdr == $past(rx_char[7:0]))
    else $error("rx byte not transferred");
  a_overrun_set: assert property (rx_done && !sleep_block && st.rx_full_flag
    && !rd_acc |=> st.overrun_flag && $stable(rdr))
    else $error("overrun not flagged");
  a_sleep_blocks: assert property (sleep_block
    |=> !$rose(st.rx_full_flag) && !$rose(st.idle_flag))
    else $error("flag set while asleep");
  a_idle_needs_char: assert property ($rose(st.idle_flag)
    |-> $past(idle_armed)) else $error("idle without character");
  a_addr_wake: assert property (addr_wake |=> !c2.rx_sleep_bit
    && st.rx_full_flag) else $error("no address wake");
  a_bit_spacing: assert property (tx_bit_tick
    |=> (!tx_bit_tick) [*8]) else $error("bit tick too close");

  c_break_sent: cover property (tx_state == spw_pkg::TX_BREAK
    && tx_bit_tick && tx_bit == nbits - 4'h1);
  c_frame_rx: cover property (rx_done && !rx_fe && !rx_nz);
  c_idle_wake: cover property (c2.rx_sleep_bit && idle_hit
    && !c1.wake_addr);
  c_noise_seen: cover property (rx_done && rx_nz);
endmodule : spw_serial_port

//--- common/spw_pkg.sv
// package: register map, field layouts, reset values and states
package spw_pkg;
  // ***************************************
  // register offsets (byte addresses)
  // ***************************************
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_BAUD = 8'h10;

  // ***************************************
  // reset values
  // ***************************************
  localparam logic [5:0] CTRL_ONE_RST = 6'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'hC0;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // ***************************************
  // timing: receiver ticks per bit, vote points
  // ***************************************
  localparam logic [3:0] RT_LAST = 4'hF;
  localparam logic [3:0] RT_VOTE_A = 4'h7;
  localparam logic [3:0] RT_VOTE_B = 4'h8;
  localparam logic [3:0] RT_VOTE_C = 4'h9;
  localparam logic [3:0] BITS_FRAME8 = 4'hA;
  localparam logic [3:0] BITS_FRAME9 = 4'hB;
  // prescaler divisors for the two select bits; plain defaults
  localparam logic [3:0] PRE_DIV0 = 4'h1;
  localparam logic [3:0] PRE_DIV1 = 4'h2;
  localparam logic [3:0] PRE_DIV2 = 4'h4;
  localparam logic [3:0] PRE_DIV3 = 4'h8;

  // ***************************************
  // field layouts
  // ***************************************
  typedef struct packed {
    logic t8;
    logic frame9;
    logic wake_addr;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic last_bit_clock_sel;
  } spw_ctrl_one_t;

  typedef struct packed {
    logic tx_irq_en;
    logic tc_irq_en;
    logic rx_irq_en;
    logic idle_irq_en;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic rx_sleep_bit;
    logic send_break_bit;
  } spw_ctrl_two_t;

  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic spare;
  } spw_status_t;

  typedef struct packed {
    logic prescale_sel_hi;
    logic prescale_sel_lo;
    logic [2:0] tx_rate_sel;
    logic [2:0] rx_rate_sel;
  } spw_baud_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FRAME = 2'b01,
    TX_BREAK = 2'b11
  } spw_tx_state_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } spw_rx_state_t;
endpackage : spw_pkg

//--- rtl/spw_rate_gen.sv
// rate generator: shared prescaler and two binary rate selectors
`timescale 1ns/1ns
module spw_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire spw_pkg::spw_baud_t baud,
  output logic rx_rt_tick,
  output logic tx_rt_tick
);
  logic [3:0] pre_cnt;
  logic [3:0] next_pre_cnt;
  logic [7:0] sel_cnt;
  logic [7:0] next_sel_cnt;
  logic [3:0] pre_div;
  logic pre_tick;

  function automatic logic [7:0] sel_mask(input logic [2:0] sel);
    sel_mask = 8'(({1'b0, 8'h01} << sel) - 9'h001);
  endfunction : sel_mask

  // ***************************************
  // prescaler then selectors
  // ***************************************
  always_comb
  begin
    case ({baud.prescale_sel_hi, baud.prescale_sel_lo})
      2'b00: pre_div = spw_pkg::PRE_DIV0;
      2'b01: pre_div = spw_pkg::PRE_DIV1;
      2'b10: pre_div = spw_pkg::PRE_DIV2;
      default: pre_div = spw_pkg::PRE_DIV3;
    endcase
    pre_tick = ce && (pre_cnt >= pre_div - 4'h1);
    next_pre_cnt = pre_tick ? 4'h0 : pre_cnt + 4'h1;
    next_sel_cnt = pre_tick ? sel_cnt + 8'h01 : sel_cnt;
  end

  // one shared counter, two independent masks
  assign rx_rt_tick = pre_tick && (&(sel_cnt | ~sel_mask(baud.rx_rate_sel)));
  assign tx_rt_tick = pre_tick && (&(sel_cnt | ~sel_mask(baud.tx_rate_sel)));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt <= 4'h0;
      sel_cnt <= 8'h00;
    end
    else if (ce)
    begin
      pre_cnt <= next_pre_cnt;
      sel_cnt <= next_sel_cnt;
    end
  end
endmodule : spw_rate_gen

//--- dv/spw_line_partner.sv
// line partner: remote serial sender and receiver on the port pins
`timescale 1ns/1ns
module spw_line_partner (
  input wire logic pclk,
  input wire logic tx_data_o,
  input wire logic tx_data_oe,
  output logic rx_line
);
  logic line_in;
  // a released transmit pin is held high by the line pull-up
  assign line_in = tx_data_oe ? tx_data_o : 1'b1;
  initial rx_line = 1'b1;

  // receive side bit time fixed at 16 cycles (fastest rate)
  task automatic send(input logic [8:0] d, input int n, input logic stop,
    input logic glitch);
    rx_line <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      rx_line <= d[i];
      if (glitch && i == 0)
      begin
        repeat (8) @(posedge pclk);
        // one-cycle spike on the middle vote of the bit
        rx_line <= ~d[i];
        @(posedge pclk);
        rx_line <= d[i];
        repeat (7) @(posedge pclk);
      end
      else
        repeat (16) @(posedge pclk);
    end
    rx_line <= stop;
    repeat (16) @(posedge pclk);
    rx_line <= 1'b1;
  endtask : send

  task automatic grab(input int bc, input int n, output logic [8:0] d,
    output logic stop, output logic ok);
    int k = 0;
    d = 9'h000;
    while (line_in !== 1'b0 && k < 2000)
    begin
      @(posedge pclk);
      k++;
    end
    repeat (bc / 2) @(posedge pclk);
    ok = (line_in === 1'b0);
    for (int i = 0; i < n; i++)
    begin
      repeat (bc) @(posedge pclk);
      d[i] = line_in;
    end
    repeat (bc) @(posedge pclk);
    stop = line_in;
  endtask : grab
endmodule : spw_line_partner

//--- dv/spw_serial_port_tb.sv
// testbench: registers, transmit, receive, break and wake-up scenarios
`timescale 1ns/1ns
module spw_serial_port_tb;
  localparam logic [7:0] A_DT = spw_pkg::ADDR_DATA;
  localparam logic [7:0] A_C1 = spw_pkg::ADDR_CTRL_ONE;
  localparam logic [7:0] A_C2 = spw_pkg::ADDR_CTRL_TWO;
  localparam logic [7:0] A_ST = spw_pkg::ADDR_STATUS;
  localparam logic [7:0] A_BD = spw_pkg::ADDR_BAUD;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rx_line, tx_data_o, tx_data_oe, sclk_o, sclk_oe;
  logic irq, rerr, sprev, ok, stp;
  logic [8:0] got;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_sclk = 0;

  always #5 pclk = ~pclk;

  spw_serial_port i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .tx_data_o(tx_data_o), .tx_data_oe(tx_data_oe),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .irq(irq));
  spw_line_partner i_far (.pclk(pclk), .tx_data_o(tx_data_o),
    .tx_data_oe(tx_data_oe), .rx_line(rx_line));

  // ****
  // sync clock edge count and run limit
  // ****
  always @(posedge pclk)
  begin
    sprev <= sclk_o;
    if (sclk_o === 1'b1 && sprev === 1'b0)
      n_sclk <= n_sclk + 1;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // ****
  // bus and helpers
  // ****
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // the wait ends once pready is high; the run limit ends it otherwise
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic st(input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, A_ST, 8'h00);
    chk("status", rdat[7:0] & m, e);
  endtask : st

  task automatic wait_low();
    int k = 0;
    while (tx_data_o !== 1'b0 && k < 100)
    begin
      @(posedge pclk);
      k++;
    end
  endtask : wait_low

  // ****
  // scenarios
  // ****
  task automatic t_tx(input logic [7:0] c1, input logic [7:0] d,
    input int bc, input int np);
    int n = c1[4] ? 9 : 8;
    apb(1'b1, A_C1, c1);
    apb(1'b1, A_C2, 8'h08);
    n_sclk = 0;
    apb(1'b1, A_DT, d);
    i_far.grab(bc, n, got, stp, ok);
    chk("start", {7'h00, ok}, 8'h01);
    chk("tx data", got[7:0], d);
    if (n == 9)
      chk("ninth", {7'h00, got[8]}, {7'h00, c1[6]});
    chk("stop", {7'h00, stp}, 8'h01);
    chk("sclk", n_sclk[7:0], np[7:0]);
    repeat (bc) @(posedge pclk);
    st(8'hC0, 8'hC0);
  endtask : t_tx

  task automatic t_break();
    int hi = 0;
    apb(1'b1, A_C2, 8'h09);
    wait_low();
    repeat (160)
    begin
      @(posedge pclk);
      if (tx_data_o !== 1'b0)
        hi++;
    end
    chk("break", hi[7:0], 8'h00);
    apb(1'b1, A_C2, 8'h08);
    repeat (200) @(posedge pclk);
    chk("idle", {7'h00, tx_data_o}, 8'h01);
  endtask : t_break

  task automatic t_disable();
    apb(1'b1, A_DT, 8'h5A);
    wait_low();
    // transmitter off, completion interrupt enabled
    apb(1'b1, A_C2, 8'h40);
    repeat (100) @(posedge pclk);
    chk("oe busy", {7'h00, tx_data_oe}, 8'h01);
    chk("tc irq busy", {7'h00, irq}, 8'h00);
    repeat (100) @(posedge pclk);
    chk("oe off", {7'h00, tx_data_oe}, 8'h00);
    chk("sclk oe", {7'h00, sclk_oe}, 8'h00);
    st(8'h40, 8'h40);
    chk("tc irq", {7'h00, irq}, 8'h01);
  endtask : t_disable

  task automatic rx_one(input logic [7:0] d, input logic s, input logic g);
    i_far.send({1'b0, d}, 8, s, g);
    // gap between characters keeps the partner's line idle
    repeat (16) @(posedge pclk);
  endtask : rx_one

  task automatic t_rx();
    apb(1'b1, A_C2, 8'h34);
    repeat (200) @(posedge pclk);
    st(8'h10, 8'h00);
    chk("idle irq early", {7'h00, irq}, 8'h00);
    rx_one(8'h3C, 1'b1, 1'b0);
    chk("irq", {7'h00, irq}, 8'h01);
    st(8'h3E, 8'h20);
    apb(1'b0, A_DT, 8'h00);
    chk("rx data", rdat[7:0], 8'h3C);
    chk("irq off", {7'h00, irq}, 8'h00);
    repeat (200) @(posedge pclk);
    st(8'h10, 8'h10);
    chk("idle irq", {7'h00, irq}, 8'h01);
    apb(1'b1, A_ST, 8'h10);
    rx_one(8'h11, 1'b1, 1'b0);
    rx_one(8'h22, 1'b1, 1'b0);
    st(8'h08, 8'h08);
    apb(1'b0, A_DT, 8'h00);
    chk("kept", rdat[7:0], 8'h11);
    apb(1'b1, A_ST, 8'h08);
    rx_one(8'h55, 1'b1, 1'b1);
    st(8'h06, 8'h04);
    apb(1'b0, A_DT, 8'h00);
    chk("voted", rdat[7:0], 8'h55);
    apb(1'b1, A_ST, 8'h04);
    rx_one(8'h66, 1'b0, 1'b0);
    st(8'h02, 8'h02);
    apb(1'b0, A_DT, 8'h00);
    apb(1'b1, A_ST, 8'h1E);
  endtask : t_rx

  task automatic t_wake();
    apb(1'b1, A_C1, 8'h08);
    apb(1'b1, A_C2, 8'h06);
    rx_one(8'h05, 1'b1, 1'b0);
    st(8'h3E, 8'h00);
    rx_one(8'h85, 1'b1, 1'b0);
    apb(1'b0, A_C2, 8'h00);
    chk("addr wake", rdat[7:0] & 8'h02, 8'h00);
    apb(1'b0, A_DT, 8'h00);
    chk("addr char", rdat[7:0], 8'h85);
    apb(1'b1, A_C1, 8'h00);
    apb(1'b1, A_C2, 8'h06);
    rx_one(8'h05, 1'b1, 1'b0);
    repeat (84) @(posedge pclk);
    apb(1'b0, A_C2, 8'h00);
    chk("asleep", rdat[7:0] & 8'h02, 8'h02);
    repeat (100) @(posedge pclk);
    apb(1'b0, A_C2, 8'h00);
    chk("idle wake", rdat[7:0] & 8'h02, 8'h00);
  endtask : t_wake

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_ST, 8'h00);
    chk("st reset", rdat[7:0], spw_pkg::STATUS_RST);
    apb(1'b0, 8'h14, 8'h00);
    chk("unmapped", {rerr, rdat[6:0]}, 8'h80);
    chk("oe reset", {7'h00, tx_data_oe}, 8'h00);
    apb(1'b1, A_BD, 8'h00);
    t_tx(8'h00, 8'hA5, 16, 7);
    t_tx(8'h01, 8'h3C, 16, 8);
    t_tx(8'h04, 8'hC3, 16, 7);
    t_break();
    t_disable();
    t_rx();
    t_wake();
    apb(1'b1, A_C2, 8'h00);
    apb(1'b1, A_BD, 8'h08);
    t_tx(8'h00, 8'h96, 32, 7);
    t_tx(8'h52, 8'h69, 32, 8);
    stop_test();
  end
endmodule : spw_serial_port_tb
